// ===== logic/hscp_slave.sv
// device-side slave of a four-wire host serial control port
// assumes serial clock, select and command line are asynchronous pins
//
// Notes on behaviour
// - one or two command bytes per transaction
// - reply bits leave bit 7 first
// - command sampled on rising clock while selected
// - command acts only when select rises
// - either clock idle polarity works for commands; with the clock idle low the reply bits arrive one clock late
// - reply released within 1.0 us of deselect
// - reply driven only after falling clock edge
`timescale 1ns/1ps
module hscp_slave #(
    parameter int unsigned BYTE_W = hscp_pkg::BYTE_W
) (
    input  wire logic              MCLK_I,
    input  wire logic              RST_I,
    input  wire logic              SCLK_I,
    input  wire logic              SELECT_N_I,
    input  wire logic              CMD_I,
    input  wire logic [BYTE_W-1:0] REPLY_BYTE_I,
    output logic                   REPLY_LINE_O,
    output logic                   REPLY_LINE_OE_O,
    output logic [BYTE_W-1:0]      CMD_BYTE0_O,
    output logic [BYTE_W-1:0]      CMD_BYTE1_O,
    output logic [1:0]             CMD_COUNT_O,
    output logic                   CMD_VALID_O
);
    import hscp_pkg::*;

    // ****************************************************
    // input synchronisers
    // ****************************************************
    logic [1:0] sclk_s_reg;
    logic [1:0] sel_s_reg;
    logic [1:0] cmd_s_reg;
    logic       sclk_d_reg;
    logic       sel_d_reg;

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            sclk_s_reg <= SYNC_LOW;
            sel_s_reg  <= SYNC_HIGH;
            cmd_s_reg  <= SYNC_LOW;
            sclk_d_reg <= 1'b0;
            sel_d_reg  <= 1'b1;
        end else begin
            sclk_s_reg <= {sclk_s_reg[0], SCLK_I};
            sel_s_reg  <= {sel_s_reg[0], SELECT_N_I};
            cmd_s_reg  <= {cmd_s_reg[0], CMD_I};
            sclk_d_reg <= sclk_s_reg[1];
            sel_d_reg  <= sel_s_reg[1];
        end
    end

    logic sclk_q;
    logic sel_q;
    logic cmd_q;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_rise;
    logic sel_fall;
    assign sclk_q    = sclk_s_reg[1];
    assign sel_q     = sel_s_reg[1];
    assign cmd_q     = cmd_s_reg[1];
    assign sclk_rise = sclk_q & ~sclk_d_reg;
    assign sclk_fall = ~sclk_q & sclk_d_reg;
    assign sel_rise  = sel_q & ~sel_d_reg;
    assign sel_fall  = ~sel_q & sel_d_reg;

    // ****************************************************
    // transaction state
    // ****************************************************
    localparam int unsigned CW = $clog2(BYTE_W);
    localparam logic [CW-1:0]     BIT_LAST  = CW'(BYTE_W - 1);
    localparam logic [1:0]        CNT_MAX   = 2'(CMD_MAX_BYTES);
    localparam logic [BYTE_W-1:0] ZERO_WORD = BYTE_W'(BYTE_ZERO);

    // ****************************************************
    // helpers
    // ****************************************************
    // one bit in at the bottom, so the msb leaves first
    function automatic logic [BYTE_W-1:0] shift_in(
        input logic [BYTE_W-1:0] word,
        input logic              bit_in
    );
        return {word[BYTE_W-2:0], bit_in};
    endfunction

    // bit counter sits on the last bit of a byte
    function automatic logic is_last(input logic [CW-1:0] cnt);
        return (cnt == BIT_LAST);
    endfunction

    // ****************************************************
    // command receiver
    // ****************************************************
    logic [BYTE_W-1:0] shift_reg, shift_next;
    logic [CW-1:0]     bitcnt_reg, bitcnt_next;
    logic [1:0]        nbytes_reg, nbytes_next;
    logic [BYTE_W-1:0] b0_reg, b0_next;
    logic [BYTE_W-1:0] b1_reg, b1_next;
    logic [BYTE_W-1:0] out_b0_reg, out_b0_next;
    logic [BYTE_W-1:0] out_b1_reg, out_b1_next;
    logic [1:0]        out_cnt_reg, out_cnt_next;
    logic              valid_reg, valid_next;

    always_comb begin
        shift_next   = shift_reg;
        bitcnt_next  = bitcnt_reg;
        nbytes_next  = nbytes_reg;
        b0_next      = b0_reg;
        b1_next      = b1_reg;
        out_b0_next  = out_b0_reg;
        out_b1_next  = out_b1_reg;
        out_cnt_next = out_cnt_reg;
        valid_next   = 1'b0;
        if (sel_fall) begin
            // new frame; clock idle level does not matter
            bitcnt_next = '0;
            nbytes_next = CNT_NONE;
        end
        if (!sel_q && sclk_rise) begin
            // command bit in, first bit ends up at bit 7
            shift_next  = shift_in(shift_reg, cmd_q);
            bitcnt_next = bitcnt_reg + 1'b1;
            if (is_last(bitcnt_reg)) begin
                // keep up to two command bytes
                if (nbytes_reg == CNT_NONE) begin
                    b0_next = shift_in(shift_reg, cmd_q);
                end else if (nbytes_reg == CNT_ONE) begin
                    b1_next = shift_in(shift_reg, cmd_q);
                end
                if (nbytes_reg < CNT_MAX) begin
                    nbytes_next = nbytes_reg + CNT_ONE;
                end
            end
        end
        if (sel_rise && (nbytes_reg != CNT_NONE)) begin
            // the command acts only now
            out_b0_next  = b0_reg;
            out_b1_next  = (nbytes_reg == CNT_MAX) ? b1_reg : ZERO_WORD;
            out_cnt_next = nbytes_reg;
            valid_next   = 1'b1;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            shift_reg   <= '0;
            bitcnt_reg  <= '0;
            nbytes_reg  <= CNT_NONE;
            b0_reg      <= '0;
            b1_reg      <= '0;
            out_b0_reg  <= '0;
            out_b1_reg  <= '0;
            out_cnt_reg <= CNT_NONE;
            valid_reg   <= 1'b0;
        end else begin
            shift_reg   <= shift_next;
            bitcnt_reg  <= bitcnt_next;
            nbytes_reg  <= nbytes_next;
            b0_reg      <= b0_next;
            b1_reg      <= b1_next;
            out_b0_reg  <= out_b0_next;
            out_b1_reg  <= out_b1_next;
            out_cnt_reg <= out_cnt_next;
            valid_reg   <= valid_next;
        end
    end

    // ****************************************************
    // reply transmitter
    // ****************************************************
    logic [BYTE_W-1:0] rsh_reg, rsh_next;
    logic [CW-1:0]     rcnt_reg, rcnt_next;
    logic              rbit_reg, rbit_next;
    logic              oe_reg, oe_next;

    always_comb begin
        rsh_next  = rsh_reg;
        rcnt_next = rcnt_reg;
        rbit_next = rbit_reg;
        oe_next   = oe_reg;
        if (sel_fall) begin
            // first reply byte is taken as the frame opens
            rsh_next  = REPLY_BYTE_I;
            rcnt_next = '0;
        end
        if (!sel_q && sclk_fall) begin
            // drive only from a falling edge, msb first
            oe_next   = 1'b1;
            rbit_next = rsh_reg[BYTE_W-1];
            rsh_next  = shift_in(rsh_reg, 1'b0);
            rcnt_next = rcnt_reg + 1'b1;
            if (is_last(rcnt_reg)) begin
                rsh_next = REPLY_BYTE_I;
            end
        end
        if (sel_rise) begin
            // release the line well inside the limit
            oe_next = 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rsh_reg  <= '0;
            rcnt_reg <= '0;
            rbit_reg <= 1'b0;
            oe_reg   <= 1'b0;
        end else begin
            rsh_reg  <= rsh_next;
            rcnt_reg <= rcnt_next;
            rbit_reg <= rbit_next;
            oe_reg   <= oe_next;
        end
    end

    assign REPLY_LINE_O    = rbit_reg;
    assign REPLY_LINE_OE_O = oe_reg;
    assign CMD_BYTE0_O     = out_b0_reg;
    assign CMD_BYTE1_O     = out_b1_reg;
    assign CMD_COUNT_O     = out_cnt_reg;
    assign CMD_VALID_O     = valid_reg;
endmodule

// ===== logic/hscp_pkg.sv
// package for the host serial control port slave
// assumes a 25 MHz system clock
package hscp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    // release time of the reply line after select goes high, in ns
    localparam int unsigned REL_TIME_NS   = 1000;
    // longest time rounds down, never less than one cycle
    localparam int unsigned REL_CYC_RAW   = REL_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned REL_CYC       =
        (REL_CYC_RAW < 1) ? 1 : REL_CYC_RAW;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned MSB_IDX       = BYTE_W - 1;
    localparam int unsigned CMD_MAX_BYTES = 2;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    // command byte counts
    localparam logic [1:0]  CNT_NONE      = 2'h0;
    localparam logic [1:0]  CNT_ONE       = 2'h1;
    // synchroniser reset levels
    localparam logic [1:0]  SYNC_LOW      = 2'h0;
    localparam logic [1:0]  SYNC_HIGH     = 2'h3;
endpackage

// ===== test/hscp_slave_properties.sv
// assertions on the serial control port slave ports
// assumes binding to hscp_slave
`timescale 1ns/1ps
module hscp_slave_properties #(
    parameter int unsigned BYTE_W = 8
) (
    input wire logic              MCLK_I,
    input wire logic              RST_I,
    input wire logic              SCLK_I,
    input wire logic              SELECT_N_I,
    input wire logic              REPLY_LINE_O,
    input wire logic              REPLY_LINE_OE_O,
    input wire logic [BYTE_W-1:0] CMD_BYTE0_O,
    input wire logic [BYTE_W-1:0] CMD_BYTE1_O,
    input wire logic [1:0]        CMD_COUNT_O,
    input wire logic              CMD_VALID_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    a_count_one_two: assert property (CMD_VALID_O |->
        CMD_COUNT_O inside {2'h1, 2'h2}) else $error("bad byte count");
    a_valid_deselect: assert property (CMD_VALID_O |->
        $past(SELECT_N_I, 3)) else $error("command acted while selected");
    a_valid_pulse: assert property (CMD_VALID_O |=>
        !CMD_VALID_O) else $error("valid longer than one cycle");
    a_cmd_hold: assert property (!CMD_VALID_O |->
        $stable({CMD_BYTE0_O, CMD_BYTE1_O, CMD_COUNT_O}))
        else $error("command outputs moved without valid");
    a_reply_release: assert property ($rose(SELECT_N_I) |->
        ##[1:25] !REPLY_LINE_OE_O) else $error("reply not released");
    a_idle_quiet: assert property (SELECT_N_I [*8] |->
        !REPLY_LINE_OE_O) else $error("reply driven while idle");
    a_drive_start: assert property ($rose(REPLY_LINE_OE_O) |->
        !$past(SCLK_I, 3)) else $error("drive before clock fall");
    a_reply_edge: assert property ($changed(REPLY_LINE_O) &&
        REPLY_LINE_OE_O |-> !$past(SCLK_I, 3)) else $error("reply moved");
endmodule

// ===== test/hscp_host_model.sv
// host side of the serial control port, frame by frame
// assumes the bench resolves the reply line before it arrives here
`timescale 1ns/1ps
module hscp_host_model (
    input  wire logic mclk_i,
    input  wire logic reply_i,
    output logic      sclk_o = 1'b1,
    output logic      select_n_o = 1'b1,
    output logic      cmd_o = 1'b0
);
    task automatic frame(input logic [15:0] d, input int nb,
                         input logic idle, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge mclk_i) #1;
        sclk_o = idle;
        #400 select_n_o = 1'b0;
        #200;
        for (int i = 0; i < nb; i++) begin
            cmd_o = d[15-i];
            sclk_o = 1'b0;
            #160 sclk_o = 1'b1;
            #150 rx = {rx[14:0], reply_i};
            #10;
        end
        #160 sclk_o = idle;
        #200 select_n_o = 1'b1;
        cmd_o = ~cmd_o;
        #1200;
    endtask
endmodule

// ===== test/hscp_slave_tb.sv
// self-checking bench for the serial control port slave
// assumes hscp_pkg, hscp_slave and the host model are compiled first
`timescale 1ns/1ps
module hscp_slave_tb;
    import hscp_pkg::*;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] rb = 8'h3C;
    logic       sclk, sel_n, cmd, rep, oe, vld;
    logic [7:0] b0, b1;
    logic [1:0] cnt;
    int         errors = 0, tests_run = 0, nv = 0;
    always #20 mclk = ~mclk;
    always @(posedge mclk) if (vld === 1'b1) nv++;
    hscp_slave dut (.MCLK_I(mclk), .RST_I(rst), .SCLK_I(sclk),
        .SELECT_N_I(sel_n), .CMD_I(cmd), .REPLY_BYTE_I(rb),
        .REPLY_LINE_O(rep), .REPLY_LINE_OE_O(oe), .CMD_BYTE0_O(b0),
        .CMD_BYTE1_O(b1), .CMD_COUNT_O(cnt), .CMD_VALID_O(vld));
    // undriven reply line shows the inverse of its last value
    hscp_host_model host (.mclk_i(mclk), .reply_i(oe ? rep : ~rep),
        .sclk_o(sclk), .select_n_o(sel_n), .cmd_o(cmd));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic t_one();
        logic [15:0] rx;
        int n = nv;
        host.frame(16'hA500, 8, 1'b1, rx);
        chk(b0, 8'hA5);
        chk(cnt, 2'h1);
        chk(rx[7:0], rb);
        chk(16'(nv - n), 16'h0001);
        chk(oe, 1'b0);
        $display("one byte frame done");
    endtask
    task automatic t_two();
        logic [15:0] rx;
        host.frame(16'h5AC3, 16, 1'b1, rx);
        chk({b0, b1}, 16'h5AC3);
        chk(cnt, 2'h2);
        chk(rx, {rb, rb});
        $display("two byte frame done");
    endtask
    task automatic t_part();
        logic [15:0] rx;
        int n = nv;
        host.frame(16'h3CE0, 11, 1'b0, rx);
        chk({b0, b1}, 16'h3C00);
        chk(cnt, 2'h1);
        chk(16'(nv - n), 16'h0001);
        chk(rx[9:2], rb);
        $display("partial byte frame done");
    endtask
    task automatic t_short();
        logic [15:0] rx;
        int n = nv;
        host.frame(16'hF000, 5, 1'b1, rx);
        chk(16'(nv - n), 16'h0000);
        chk({b0, b1}, 16'h3C00);
        chk(cnt, 2'h1);
        chk(oe, 1'b0);
        $display("short frame done");
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (3) @(posedge mclk);
        t_one();
        t_two();
        t_part();
        t_short();
        complete_run();
    end
    initial begin
        #60000 errors++;
        complete_run();
    end
endmodule
bind hscp_slave hscp_slave_properties #(.BYTE_W(BYTE_W)) chk_u (
    .MCLK_I(MCLK_I),
    .RST_I(RST_I), .SCLK_I(SCLK_I), .SELECT_N_I(SELECT_N_I),
    .REPLY_LINE_O(REPLY_LINE_O), .REPLY_LINE_OE_O(REPLY_LINE_OE_O),
    .CMD_BYTE0_O(CMD_BYTE0_O), .CMD_BYTE1_O(CMD_BYTE1_O),
    .CMD_COUNT_O(CMD_COUNT_O), .CMD_VALID_O(CMD_VALID_O));
